// *** rtl/bsd_regs.vh ***
// register offsets, field positions, encodings and reset values of the boot source decoder
`ifndef BSD_REGS_VH
`define BSD_REGS_VH

// ***************************************
// register offsets (byte addresses)
// ***************************************
`define BSD_ADDR_CTRL       8'h00
`define BSD_ADDR_STATUS     8'h04
`define BSD_ADDR_RESULT     8'h08
`define BSD_ADDR_SNAP       8'h0c

// ***************************************
// control register fields
// ***************************************
`define BSD_CTRL_REDECODE   0
`define BSD_CTRL_HOLD       1
`define BSD_CTRL_RESET      2'h0

// ***************************************
// status register fields
// ***************************************
`define BSD_ST_DONE         0
`define BSD_ST_RESERVED     1
`define BSD_ST_RELEASE      2
`define BSD_ST_SIGCHK       3
`define BSD_ST_MODE_LSB     8
`define BSD_ST_MODE_MSB     13

// ***************************************
// result register fields
// ***************************************
`define BSD_RS_DEV_LSB      0
`define BSD_RS_DEV_MSB      2
`define BSD_RS_REGION_LSB   4
`define BSD_RS_REGION_MSB   8
`define BSD_RS_TABLE        12
`define BSD_RS_KEY          13

// ***************************************
// snapshot register fields
// ***************************************
`define BSD_SN_STRAP_LSB    0
`define BSD_SN_STRAP_MSB    6
`define BSD_SN_FAST         8
`define BSD_SN_SEC          9
`define BSD_SN_FDEV_LSB     12
`define BSD_SN_FDEV_MSB     14

// ***************************************
// strap, fuse and device encodings
// ***************************************
`define BSD_STRAP_W         7
`define BSD_STRAP_SEL       6
`define BSD_STRAP_UNUSED    5
`define BSD_REGIONS         28
`define BSD_REGION_BITS     3
`define BSD_RF_AUTH         0
`define BSD_RF_TABLE        1
`define BSD_RF_KEY          2
`define BSD_REGION_LAST     5'h04
`define BSD_DEV_CC3_USB     3'h0
`define BSD_DEV_CC3_CC1     3'h1
`define BSD_DEV_CC3_CC2     3'h2
`define BSD_DEV_CC1         3'h3
`define BSD_DEV_CC2         3'h4
`define BSD_DEV_CC3         3'h5

// ***************************************
// one-hot decode modes
// ***************************************
`define BSD_MODE_W          6
`define BSD_MODE_LOCKED     6'h01
`define BSD_MODE_DEV_OPEN   6'h02
`define BSD_MODE_DEV_AUTH   6'h04
`define BSD_MODE_FUSE_REG   6'h08
`define BSD_MODE_FIXED_REG  6'h10
`define BSD_MODE_RESERVED   6'h20

`endif

// *** rtl/bsd_mode_dec.v ***
// combinational decode of fuse states and strap pins into boot device and secure settings
`timescale 1ns/10ps
`include "bsd_regs.vh"

module bsd_mode_dec (
	input  wire        fast_blown,    // fast boot device fuse blown
	input  wire [2:0]  fast_dev,      // device value held in fast boot fuse
	input  wire        sec_blown,     // secure region fuse blown
	input  wire [6:0]  strap,         // sampled strap pins
	input  wire [83:0] region_fuses,  // secure_region_fuses, 3 bits per region
	output reg  [5:0]  mode,          // one-hot decode mode
	output reg  [2:0]  boot_dev,      // selected boot device
	output reg         sig_check,     // signature_check_enable
	output reg         table_sel,     // table select of chosen region
	output reg         key_sel,       // key select of chosen region
	output reg  [4:0]  region,        // chosen region number, 0 for none
	output reg         reserved,      // unlisted combination seen
	output reg         release_pins   // strap pins free for general use
);

	// ***************************************
	// per-region fuse unpacking
	// ***************************************
	wire [27:0] r_auth;
	wire [27:0] r_table;
	wire [27:0] r_key;

	genvar gi;
	generate
		for (gi = 0; gi < `BSD_REGIONS; gi = gi + 1) begin : g_region
			assign r_auth[gi]  = region_fuses[gi*`BSD_REGION_BITS + `BSD_RF_AUTH];
			assign r_table[gi] = region_fuses[gi*`BSD_REGION_BITS + `BSD_RF_TABLE];
			assign r_key[gi]   = region_fuses[gi*`BSD_REGION_BITS + `BSD_RF_KEY];
		end
	endgenerate

	// {valid, device} for a device code; codes above the table are unlisted
	function [3:0] dev_code;
		input [4:0] code;
		begin
			if (code <= {2'h0, `BSD_DEV_CC2})
				dev_code = {1'b1, code[2:0]};   // [RL10]
			else
				dev_code = {1'b0, `BSD_DEV_CC3}; // [RL13]
		end
	endfunction

	wire [3:0] strap_dev = dev_code(strap[4:0]);
	wire [3:0] fuse_dev  = dev_code({2'h0, fast_dev});
	wire [4:0] sel       = strap[4:0];
	wire [4:0] sel_idx   = sel - 5'h01;

	// ***************************************
	// decode
	// ***************************************
	always @* begin
		mode         = `BSD_MODE_RESERVED;
		boot_dev     = `BSD_DEV_CC3;
		sig_check    = 1'b0;
		table_sel    = 1'b0;
		key_sel      = 1'b0;
		region       = 5'h00;
		reserved     = 1'b0;
		release_pins = 1'b0;
		case ({fast_blown, sec_blown, strap[`BSD_STRAP_SEL]})
			3'b110, 3'b111: begin
				// strap pins take no part at all here
				mode         = `BSD_MODE_LOCKED;          // [RL1]
				release_pins = 1'b1;                      // [RL2]
				boot_dev     = fuse_dev[2:0];
				region       = 5'h01;
				sig_check    = r_auth[0];                 // [RL3]
				table_sel    = r_table[0];                // [RL9]
				key_sel      = r_key[0];                  // [RL9]
				reserved     = ~fuse_dev[3];
			end
			3'b001: begin
				mode     = `BSD_MODE_DEV_OPEN;
				boot_dev = strap_dev[2:0];                // [RL5]
				reserved = ~strap_dev[3];
			end
			3'b011: begin
				mode      = `BSD_MODE_DEV_AUTH;
				boot_dev  = strap_dev[2:0];               // [RL6]
				region    = 5'h01;
				sig_check = r_auth[0] & strap_dev[3];     // [RL6]
				table_sel = r_table[0];                   // [RL9]
				key_sel   = r_key[0];                     // [RL9]
				reserved  = ~strap_dev[3];
			end
			3'b100, 3'b010: begin
				if (fast_blown) begin
					mode     = `BSD_MODE_FUSE_REG;
					boot_dev = fuse_dev[2:0];             // [RL7]
				end else begin
					mode     = `BSD_MODE_FIXED_REG;
					boot_dev = `BSD_DEV_CC3;              // [RL8]
				end
				if (strap[`BSD_STRAP_UNUSED] || sel > `BSD_REGION_LAST) begin
					reserved = 1'b1;                      // [RL13]
				end else if (sel != 5'h00) begin
					region    = sel;                      // [RL11]
					// secure boot only possible through region one
					sig_check = (sel == 5'h01);           // [RL12]
					table_sel = r_table[sel_idx];         // [RL9]
					key_sel   = r_key[sel_idx];           // [RL9]
				end
				if (fast_blown && !fuse_dev[3])
					reserved = 1'b1;
			end
			default: begin
				reserved = 1'b1;                          // [RL13]
			end
		endcase
		if (reserved) begin
			boot_dev  = `BSD_DEV_CC3;                     // [RL13]
			sig_check = 1'b0;
		end
	end

endmodule

// *** rtl/bsd_top.v ***
// boot source decoder: samples straps and fuses after reset, latches boot device and secure settings
//
// Behaviour
// [RL1] with both the fast boot fuse and the secure region fuse blown, strap pins 5..0 are ignored.
// [RL2] with both fuses blown, the strap pins are released for general-purpose use after decoding.
// [RL3] with both fuses blown, the secure configuration comes from the secure region fuse sets (up to 28).
// [RL4] strap pin 6 high decodes pins 5..0 as a boot device, low decodes them as a secure region.
// [RL5] neither fuse blown and pin 6 high: device from pins 4..0, pin 5 ignored, no authentication.
// [RL6] only the secure fuse blown and pin 6 high: device from straps, authentication as region fuses say.
// [RL7] only the fast fuse blown and pin 6 low: pins 4..0 pick the region, device from the fast fuse.
// [RL8] only the secure fuse blown and pin 6 low: device is always card controller three.
// [RL9] where a region is enabled, table and key select come from that region's fuse bits.
// [RL10] fast boot codes 0..4 pick cc3+usb, cc3+cc1, cc3+cc2, cc1 alone, cc2 alone.
// [RL11] secure codes: 0 disables secure boot, 1..4 enable region one to four.
// [RL12] only region one is supported; secure mode only when region one is turned on.
// [RL13] unlisted combinations are reserved and fall back to cc3 without authentication.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "bsd_regs.vh"

module bsd_top (
	input  wire        CLK,           // system clock, 100 MHz
	input  wire        RST_N,         // asynchronous reset, active low
	input  wire [6:0]  STRAP,         // boot strap pins
	input  wire        FAST_BLOWN,    // fast boot device fuse blown
	input  wire [2:0]  FAST_DEV,      // fast boot device fuse value
	input  wire        SEC_BLOWN,     // secure region fuse blown
	input  wire [83:0] REGION_FUSES,  // secure_region_fuses, 28 x 3 bits
	input  wire [7:0]  ADDR,          // register byte address
	input  wire [31:0] WDATA,         // register write data
	input  wire        WR,            // write strobe
	input  wire        RD,            // read strobe
	output reg  [31:0] RDATA,         // read data, cycle after RD
	output reg  [2:0]  BOOT_DEV,      // decoded boot device
	output reg         SIG_CHECK_EN,  // signature_check_enable
	output reg         TABLE_SEL,     // table select for authentication
	output reg         KEY_SEL,       // key select for authentication
	output reg  [4:0]  REGION,        // enabled secure region, 0 none
	output reg         RESERVED,      // reserved combination decoded
	output reg         PINS_RELEASED, // strap pins free as gpio
	output reg         DONE           // decode results valid
);

	// ***************************************
	// states
	// ***************************************
	localparam [2:0] ST_SAMPLE = 3'h1;
	localparam [2:0] ST_LATCH  = 3'h2;
	localparam [2:0] ST_DONE   = 3'h4;

	reg [2:0]  state_ff;
	reg [2:0]  nxt_state;
	reg [6:0]  strap_ff;
	reg        fast_ff;
	reg [2:0]  fdev_ff;
	reg        sec_ff;
	reg [83:0] rfuse_ff;
	reg [5:0]  mode_ff;
	reg        hold_ff;
	reg        redo_ff;

	wire [5:0] dec_mode;
	wire [2:0] dec_dev;
	wire       dec_sig;
	wire       dec_table;
	wire       dec_key;
	wire [4:0] dec_region;
	wire       dec_rsv;
	wire       dec_rel;

	wire wr_ctrl = WR && (ADDR == `BSD_ADDR_CTRL);

	// ***************************************
	// decoder
	// ***************************************
	bsd_mode_dec i_bsd_mode_dec (
		.fast_blown   (fast_ff),
		.fast_dev     (fdev_ff),
		.sec_blown    (sec_ff),
		.strap        (strap_ff),
		.region_fuses (rfuse_ff),
		.mode         (dec_mode),
		.boot_dev     (dec_dev),
		.sig_check    (dec_sig),
		.table_sel    (dec_table),
		.key_sel      (dec_key),
		.region       (dec_region),
		.reserved     (dec_rsv),
		.release_pins (dec_rel)
	);

	// ***************************************
	// sequencing
	// ***************************************
	// a redecode request waits while software holds the results frozen
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_SAMPLE: nxt_state = ST_LATCH;
			ST_LATCH:  nxt_state = ST_DONE;
			ST_DONE: begin
				if (redo_ff && !hold_ff)
					nxt_state = ST_SAMPLE;
			end
			default:   nxt_state = ST_SAMPLE;
		endcase
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= ST_SAMPLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// inputs are caught in the sample state, after reset release and on each redecode, never under reset itself
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			strap_ff <= 7'h00;
			fast_ff  <= 1'b0;
			fdev_ff  <= 3'h0;
			sec_ff   <= 1'b0;
			rfuse_ff <= 84'h0;
		end else if (state_ff == ST_SAMPLE) begin
			strap_ff <= STRAP;                        // [RL4]
			fast_ff  <= FAST_BLOWN;
			fdev_ff  <= FAST_DEV;
			sec_ff   <= SEC_BLOWN;
			rfuse_ff <= REGION_FUSES;                 // [RL3]
		end
	end

	// ***************************************
	// result latch
	// ***************************************
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BOOT_DEV      <= `BSD_DEV_CC3;
			SIG_CHECK_EN  <= 1'b0;
			TABLE_SEL     <= 1'b0;
			KEY_SEL       <= 1'b0;
			REGION        <= 5'h00;
			RESERVED      <= 1'b0;
			PINS_RELEASED <= 1'b0;
			DONE          <= 1'b0;
			mode_ff       <= 6'h00;
		end else if (state_ff == ST_LATCH) begin
			BOOT_DEV      <= dec_dev;
			SIG_CHECK_EN  <= dec_sig;                 // [RL12]
			TABLE_SEL     <= dec_table;
			KEY_SEL       <= dec_key;
			REGION        <= dec_region;
			RESERVED      <= dec_rsv;
			PINS_RELEASED <= dec_rel;                 // [RL2]
			DONE          <= 1'b1;
			mode_ff       <= dec_mode;
		end else if (state_ff == ST_SAMPLE) begin
			DONE          <= 1'b0;
		end
	end

	// ***************************************
	// control register
	// ***************************************
	// redecode is sticky until taken, so a write during decode is not lost
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hold_ff <= 1'b0;
			redo_ff <= 1'b0;
		end else begin
			if (wr_ctrl)
				hold_ff <= WDATA[`BSD_CTRL_HOLD];
			if (wr_ctrl && WDATA[`BSD_CTRL_REDECODE])
				redo_ff <= 1'b1;
			else if (state_ff == ST_SAMPLE)
				redo_ff <= 1'b0;
		end
	end

	// ***************************************
	// read port
	// ***************************************
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= 32'h0;
		end else if (RD) begin
			RDATA <= 32'h0;
			case (ADDR)
				`BSD_ADDR_CTRL: begin
					RDATA[`BSD_CTRL_HOLD]     <= hold_ff;
					RDATA[`BSD_CTRL_REDECODE] <= redo_ff;
				end
				`BSD_ADDR_STATUS: begin
					RDATA[`BSD_ST_DONE]     <= DONE;
					RDATA[`BSD_ST_RESERVED] <= RESERVED;
					RDATA[`BSD_ST_RELEASE]  <= PINS_RELEASED;
					RDATA[`BSD_ST_SIGCHK]   <= SIG_CHECK_EN;
					RDATA[`BSD_ST_MODE_MSB:`BSD_ST_MODE_LSB] <= mode_ff;
				end
				`BSD_ADDR_RESULT: begin
					RDATA[`BSD_RS_DEV_MSB:`BSD_RS_DEV_LSB]       <= BOOT_DEV;
					RDATA[`BSD_RS_REGION_MSB:`BSD_RS_REGION_LSB] <= REGION;
					RDATA[`BSD_RS_TABLE] <= TABLE_SEL;
					RDATA[`BSD_RS_KEY]   <= KEY_SEL;
				end
				`BSD_ADDR_SNAP: begin
					RDATA[`BSD_SN_STRAP_MSB:`BSD_SN_STRAP_LSB] <= strap_ff;
					RDATA[`BSD_SN_FAST] <= fast_ff;
					RDATA[`BSD_SN_SEC]  <= sec_ff;
					RDATA[`BSD_SN_FDEV_MSB:`BSD_SN_FDEV_LSB]   <= fdev_ff;
				end
				default: RDATA <= 32'h0;
			endcase
		end
	end

endmodule

// *** test/bsd_checker_assertions.sv ***
// port checks for the boot source decoder, bound onto its top
`timescale 1ns/10ps
module bsd_checker (
	input wire        CLK,           // system clock
	input wire        RST_N,         // async reset, active low
	input wire [6:0]  STRAP,         // strap pins
	input wire        FAST_BLOWN,    // fast fuse blown
	input wire [2:0]  FAST_DEV,      // fast fuse device
	input wire        SEC_BLOWN,     // secure fuse blown
	input wire [83:0] REGION_FUSES,  // region fuse sets
	input wire [2:0]  BOOT_DEV,      // boot device
	input wire        SIG_CHECK_EN,  // signature check
	input wire        TABLE_SEL,     // table select
	input wire [4:0]  REGION,        // region number
	input wire        RESERVED,      // reserved decode
	input wire        PINS_RELEASED, // pins freed
	input wire        DONE           // results valid
);
	// ****************************************
	// inputs as captured, two edges before done rises
	// ****************************************
	reg  [14:0] h1_ff;
	reg  [14:0] h2_ff;
	wire [6:0]  st = h2_ff[6:0];
	wire        fb = h2_ff[7];
	wire        sb = h2_ff[8];
	wire [2:0]  fd = h2_ff[11:9];
	wire [2:0]  r1 = h2_ff[14:12];
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			h1_ff <= 15'h0000;
			h2_ff <= 15'h0000;
		end else begin
			h1_ff <= {REGION_FUSES[2:0], FAST_DEV, SEC_BLOWN, FAST_BLOWN, STRAP};
			h2_ff <= h1_ff;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_RELEASE:
	assert property ($rose(DONE) |-> PINS_RELEASED == (fb && sb)) else $error("released flag wrong");
	AST_BOTH:
	assert property ($rose(DONE) && fb && sb && fd < 3'h5 |-> BOOT_DEV == fd && SIG_CHECK_EN == r1[0])
		else $error("both-blown decode wrong");
	AST_TABLE:
	assert property ($rose(DONE) && fb && sb && fd < 3'h5 |-> TABLE_SEL == r1[1]) else $error("table select wrong");
	AST_OPEN:
	assert property ($rose(DONE) && !fb && !sb && st[6] && st[4:0] < 5'h05 |-> BOOT_DEV == st[2:0] && !SIG_CHECK_EN)
		else $error("open device decode wrong");
	AST_FIXED:
	assert property ($rose(DONE) && !fb && sb && !st[6] |-> BOOT_DEV == 3'h5) else $error("fixed device wrong");
	AST_FUSEDEV:
	assert property ($rose(DONE) && fb && !sb && !st[6] && st[5:0] < 6'h05 && fd < 3'h5 |-> BOOT_DEV == fd)
		else $error("fuse device wrong");
	AST_REGION:
	assert property ($rose(DONE) && fb != sb && !st[6] && st[5:0] > 6'h01 && st[5:0] < 6'h05
		|-> REGION == st[4:0] && !SIG_CHECK_EN) else $error("region decode wrong");
	AST_NOSEC:
	assert property ($rose(DONE) && fb != sb && !st[6] && st[5:0] == 6'h00 |-> REGION == 5'h00 && !SIG_CHECK_EN)
		else $error("secure boot not off");
	AST_RESV:
	assert property (RESERVED |-> BOOT_DEV == 3'h5 && !SIG_CHECK_EN) else $error("reserved fallback wrong");
	AST_HOLD:
	assert property (DONE && $past(DONE) |-> $stable(BOOT_DEV) && $stable(PINS_RELEASED))
		else $error("results moved without decode");
	cover property ($rose(DONE) && fb && sb);
	cover property ($rose(DONE) && !fb && sb && !st[6]);
	cover property ($rose(RESERVED));
endmodule

bind bsd_top bsd_checker i_bsd_checker (.CLK, .RST_N, .STRAP, .FAST_BLOWN, .FAST_DEV, .SEC_BLOWN,
	.REGION_FUSES, .BOOT_DEV, .SIG_CHECK_EN, .TABLE_SEL, .REGION, .RESERVED, .PINS_RELEASED, .DONE);

// *** test/bsd_board.sv ***
// board model: strap resistors, and the straps reused as gpio once freed
`timescale 1ns/10ps
module bsd_board (
	input  wire       clk,       // system clock
	input  wire [6:0] strap_set, // strap resistor pattern
	input  wire       gpio_en,   // software drives the freed pins
	input  wire       released,  // decoder has freed the pins
	output wire [6:0] strap      // level on the strap pins
);
	reg [5:0] gpio_ff;
	initial gpio_ff = 6'h2a;
	// moving pattern so a late capture would show
	always @(posedge clk) begin
		gpio_ff <= gpio_ff + 6'h15;
	end
	assign strap = (gpio_en && released) ? {strap_set[6], gpio_ff} : strap_set;
endmodule

// *** test/test_bsd_top.sv ***
// self-checking bench for the boot source decoder
`timescale 1ns/10ps
`include "bsd_regs.vh"
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module test_bsd_top;
	localparam [83:0] FZ = 84'h533;
	reg         clk, rst_n, wr, rd, fast, sec, gpio_en;
	reg  [2:0]  fdev;
	reg  [6:0]  strap_set;
	reg  [83:0] fz;
	reg  [7:0]  addr;
	reg  [31:0] wdata, d;
	wire [6:0]  strap;
	wire [31:0] rdata;
	wire [2:0]  boot_dev;
	wire [4:0]  region;
	wire        sig, tsel, ksel, resv, rel, done;
	integer     n_fail, compares;
	bsd_board i_bsd_board (.clk(clk), .strap_set(strap_set), .gpio_en(gpio_en), .released(rel), .strap(strap));
	bsd_top i_bsd_top (.CLK(clk), .RST_N(rst_n), .STRAP(strap), .FAST_BLOWN(fast), .FAST_DEV(fdev),
		.SEC_BLOWN(sec), .REGION_FUSES(fz), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.BOOT_DEV(boot_dev), .SIG_CHECK_EN(sig), .TABLE_SEL(tsel), .KEY_SEL(ksel), .REGION(region),
		.RESERVED(resv), .PINS_RELEASED(rel), .DONE(done));
	// ****************************************
	// bus and decode helpers
	// ****************************************
	task wr_reg(input [7:0] a, input [31:0] v);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= v;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rd_reg(input [7:0] a, output [31:0] v);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 v = rdata;
		end
	endtask
	// inputs held steady through capture; done awaited under a bound
	task run(input [6:0] s, input f, input [2:0] fd, input sc, input [83:0] z);
		integer i;
		begin
			@(posedge clk);
			strap_set <= s;
			fast <= f;
			fdev <= fd;
			sec <= sc;
			fz <= z;
			wr_reg(`BSD_ADDR_CTRL, 32'h0000_0001);
			repeat (2) @(posedge clk);
			#1;
			for (i = 0; i < 8 && done !== 1'b1; i = i + 1) begin
				@(posedge clk);
				#1;
			end
		end
	endtask
	task chk(input [2:0] dv, input sg, input rs);
		begin
			`CHK("done", 1'b1, done)
			`CHK("boot_dev", dv, boot_dev)
			`CHK("sig_check", sg, sig)
			`CHK("reserved", rs, resv)
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_open;
		integer c;
		begin
			for (c = 0; c < 6; c = c + 1) begin
				run(7'h60 | c[6:0], 1'b0, 3'h0, 1'b0, 84'h0);
				chk(c < 5 ? c[2:0] : `BSD_DEV_CC3, 1'b0, c == 5);
			end
			$display("t_open finished");
		end
	endtask
	task t_dev_auth;
		begin
			run(7'h42, 1'b0, 3'h0, 1'b1, 84'h3);
			chk(`BSD_DEV_CC3_CC2, 1'b1, 1'b0);
			`CHK("table_sel", 1'b1, tsel)
			run(7'h42, 1'b0, 3'h0, 1'b1, 84'h6);
			chk(`BSD_DEV_CC3_CC2, 1'b0, 1'b0);
			$display("t_dev_auth finished");
		end
	endtask
	task t_fuse_region;
		integer c;
		begin
			for (c = 0; c < 6; c = c + 1) begin
				run(c[6:0], 1'b1, 3'h4, 1'b0, FZ);
				chk(c < 5 ? 3'h4 : 3'h5, c == 1, c == 5);
				if (c > 0 && c < 5) begin
					`CHK("table_sel", FZ[3*c-2], tsel)
					`CHK("key_sel", FZ[3*c-1], ksel)
				end
				if (c != 1 && c < 5)
					`CHK("region", c[4:0], region)
			end
			run(7'h21, 1'b1, 3'h4, 1'b0, FZ);
			chk(`BSD_DEV_CC3, 1'b0, 1'b1);
			$display("t_fuse_region finished");
		end
	endtask
	task t_fixed;
		begin
			run(7'h03, 1'b0, 3'h1, 1'b1, FZ);
			chk(`BSD_DEV_CC3, 1'b0, 1'b0);
			`CHK("region", 5'h03, region)
			rd_reg(`BSD_ADDR_RESULT, d);
			`CHK("result", 32'h0000_2035, d)
			run(7'h01, 1'b0, 3'h1, 1'b1, FZ);
			chk(`BSD_DEV_CC3, 1'b1, 1'b0);
			$display("t_fixed finished");
		end
	endtask
	task t_both;
		begin
			run(7'h7f, 1'b1, 3'h3, 1'b1, 84'h5);
			chk(`BSD_DEV_CC1, 1'b1, 1'b0);
			`CHK("key_sel", 1'b1, ksel)
			`CHK("released", 1'b1, rel)
			rd_reg(`BSD_ADDR_STATUS, d);
			`CHK("status", 32'h0000_010d, d)
			@(posedge clk);
			gpio_en <= 1'b1;
			// redecode while the freed pins toggle: the result must not move
			run(7'h7f, 1'b1, 3'h3, 1'b1, 84'h5);
			chk(`BSD_DEV_CC1, 1'b1, 1'b0);
			@(posedge clk);
			gpio_en <= 1'b0;
			run(7'h7f, 1'b1, 3'h6, 1'b1, 84'h5);
			chk(`BSD_DEV_CC3, 1'b0, 1'b1);
			$display("t_both finished");
		end
	endtask
	task t_reserved;
		begin
			run(7'h01, 1'b0, 3'h0, 1'b0, FZ);
			chk(`BSD_DEV_CC3, 1'b0, 1'b1);
			run(7'h41, 1'b1, 3'h2, 1'b0, FZ);
			chk(`BSD_DEV_CC3, 1'b0, 1'b1);
			rd_reg(8'h10, d);
			`CHK("unmapped", 32'h0, d)
			$display("t_reserved finished");
		end
	endtask
	task t_hold;
		begin
			run(7'h43, 1'b0, 3'h0, 1'b0, 84'h0);
			@(posedge clk);
			strap_set <= 7'h44;
			// redecode asked while held stays pending, results frozen
			wr_reg(`BSD_ADDR_CTRL, 32'h0000_0003);
			repeat (4) @(posedge clk);
			#1 chk(`BSD_DEV_CC1, 1'b0, 1'b0);
			rd_reg(`BSD_ADDR_CTRL, d);
			`CHK("ctrl", 32'h0000_0003, d)
			wr_reg(`BSD_ADDR_CTRL, 32'h0000_0000);
			repeat (3) @(posedge clk);
			#1 chk(`BSD_DEV_CC2, 1'b0, 1'b0);
			rd_reg(`BSD_ADDR_SNAP, d);
			`CHK("snap", 32'h0000_0044, d)
			// reset in mid-run, then a fresh decode after release
			@(posedge clk);
			rst_n <= 1'b0;
			@(posedge clk);
			#1 `CHK("done", 1'b0, done)
			`CHK("boot_dev", `BSD_DEV_CC3, boot_dev)
			@(posedge clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge clk);
			#1 chk(`BSD_DEV_CC2, 1'b0, 1'b0);
			$display("t_hold finished");
		end
	endtask
	task final_report;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		n_fail = n_fail + 1;
		$display("[ERR] watchdog expired");
		final_report;
	end
	initial begin
		n_fail = 0;
		compares = 0;
		{rst_n, wr, rd, fast, sec, gpio_en, fdev, addr, wdata, fz} = 0;
		strap_set = 7'h43;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(`BSD_DEV_CC1, 1'b0, 1'b0);
		t_open;
		t_dev_auth;
		t_fuse_region;
		t_fixed;
		t_both;
		t_reserved;
		t_hold;
		final_report;
	end
endmodule
